// file: common/swt_pkg.sv
package swt_pkg;
  // What this block does
  // - Resolution bits pick 9 to 12 bits; max conversion time 93.75 to 750 ms.
  // - Code check byte covers the first 56 code bits and sits in the top byte.
  // - Both check bytes use polynomial x^8 + x^5 + x^4 + 1.
  // - Scratchpad check byte is ninth byte, recomputed from current contents.
  // - Device never halts a sequence on a check mismatch; master decides.
  // - All command and data bytes travel least significant bit first.
  // - Line driven only open-drain and released when idle; idles high.
  // - Line low over 480 us is a bus reset; any transaction is dropped.
  // - Gaps between bits may be any length while the line stays high.
  // - Only reset, addressing command, then function command is obeyed.
  // - Every transaction opens with a reset; device answers with presence.
  // - Five eight-bit addressing commands act on the 64-bit code.
  // - Code search takes part in bitwise elimination of codes.
  // - Read-code command sends the whole 64-bit code.
  // - Match-code takes 64 bits; only an exact match answers afterwards.
  // - Skip-code addresses every device without a code.
  // - After reset rise wait 15-60 us, then drive low 60-240 us.
  // - Alarm search acts like code search, only with alarm flag set.
  // - Code is type byte low, 48-bit serial next, check byte on top.
  localparam int CLK_MHZ = 200;
  localparam int T_RST_US = 480;
  localparam int T_PW_US = 30;
  localparam int T_PL_US = 120;
  localparam int T_SMP_US = 30;
  localparam int T_CONV_MS = 750;
  localparam int RST_CYC = T_RST_US * CLK_MHZ;
  localparam int PW_CYC = T_PW_US * CLK_MHZ;
  localparam int PL_CYC = T_PL_US * CLK_MHZ;
  localparam int SMP_CYC = T_SMP_US * CLK_MHZ;
  localparam int CONV_CYC = T_CONV_MS * 1000 * CLK_MHZ;
  localparam int CW = 17;
  localparam int VW = 28;
  localparam logic [7:0] CRC_POLY_REV = 8'h8c;
  localparam logic [7:0] CMD_READ_CODE = 8'h33;
  localparam logic [7:0] CMD_MATCH_CODE = 8'h55;
  localparam logic [7:0] CMD_SKIP_CODE = 8'hcc;
  localparam logic [7:0] CMD_SEARCH = 8'hf0;
  localparam logic [7:0] CMD_ALARM_SEARCH = 8'hec;
  localparam logic [7:0] CMD_CONVERT = 8'h44;
  localparam logic [7:0] CMD_WRITE_SP = 8'h4e;
  localparam logic [7:0] CMD_READ_SP = 8'hbe;
  localparam int CFG_RES_HI_POS = 6;
  localparam int CFG_RES_LO_POS = 5;
  localparam logic CFG_BIT7_VAL = 1'b0;
  localparam logic [4:0] CFG_LOW_VAL = 5'h1f;
  localparam logic [1:0] RES_RESET = 2'h3;
  localparam logic [15:0] TEMP_RESET = 16'h0550;
  localparam logic [7:0] TH_RESET = 8'h00;
  localparam logic [7:0] TL_RESET = 8'h00;
  localparam logic [23:0] SP_RSVD = 24'h100cff;
  typedef enum logic [10:0] {
    ST_IDLE = 11'h001,
    ST_WRISE = 11'h002,
    ST_PWAIT = 11'h004,
    ST_PLOW = 11'h008,
    ST_ROMCMD = 11'h010,
    ST_READROM = 11'h020,
    ST_MATCH = 11'h040,
    ST_SEARCH = 11'h080,
    ST_FNCMD = 11'h100,
    ST_WRSP = 11'h200,
    ST_RDSP = 11'h400
  } swt_st_type;
endpackage

// file: hdl/swt_crc8.sv
`timescale 1ns/1ps
module swt_crc8
  import swt_pkg::*;
#(
  parameter int NBYTES = 7
) (
  input wire logic [8*NBYTES-1:0] data_i,
  output logic [7:0] crc_o
);
  logic [7:0] c [0:8*NBYTES];

  // Bit-serial chain, LSB first, reflected x^8+x^5+x^4+1
  assign c[0] = 8'h00;
  for (genvar i = 0; i < 8 * NBYTES; i++) begin : g_bit
    assign c[i+1] = {1'b0, c[i][7:1]} ^ ((c[i][0] ^ data_i[i]) ? CRC_POLY_REV : 8'h00);
  end
  assign crc_o = c[8*NBYTES];
endmodule

// file: hdl/swt_fifo.sv
`timescale 1ns/1ps
module swt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam int NW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem_ff [0:DEPTH-1];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [NW-1:0] num_ff;
  logic push;
  logic pop;

  // Honest flags straight from the fill count
  assign in_ready_o = num_ff != NW'(DEPTH);
  assign out_valid_o = num_ff != '0;
  assign out_data_o = mem_ff[rd_ff];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Storage needs no reset; the count guards every read
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data_i;
    end
  end

  // Pointers wrap by value so non power-of-two depths work
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ff <= '0;
      rd_ff <= '0;
      num_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + AW'(1);
      end
      if (pop) begin
        rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + AW'(1);
      end
      num_ff <= num_ff + NW'(push) - NW'(pop);
    end
  end
endmodule

// file: hdl/swt_wire_slave.sv
`timescale 1ns/1ps
module swt_wire_slave
  import swt_pkg::*;
#(
  parameter int RST_N = RST_CYC,
  parameter int PW_N = PW_CYC,
  parameter int PL_N = PL_CYC,
  parameter int SMP_N = SMP_CYC,
  parameter int CONV_N = CONV_CYC,
  parameter int FIFO_DEPTH = 8,
  // Serial value is arbitrary
  parameter logic [47:0] SERIAL = 48'h0000_1234_5678,
  // Type code value is arbitrary
  parameter logic [7:0] TYPE_CODE = 8'h5a
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic dq_i,
  output logic dq_o,
  output logic dq_oe_o,
  input wire logic [15:0] temp_i,
  input wire logic alarm_i,
  output logic conv_busy_o,
  output logic [1:0] resolution_o,
  output logic [7:0] fn_byte_o,
  output logic fn_valid_o,
  input wire logic fn_ready_i
);
  swt_st_type st_ff;
  logic dq_q_ff;
  logic [CW-1:0] low_cnt_ff;
  logic [CW-1:0] tm_ff;
  logic slot_ff;
  logic drv_ff;
  logic [6:0] cnt_ff;
  logic [1:0] sub_ff;
  logic [7:0] sh_ff;
  logic [7:0] th_ff;
  logic [7:0] tl_ff;
  logic [1:0] res_ff;
  logic [15:0] temp_ff;
  logic [VW-1:0] conv_cnt_ff;
  logic rst_hit;
  logic fall;
  logic bit_stb;
  logic rb;
  logic [7:0] rx_byte;
  logic tx_mode;
  logic tx_bit;
  logic slot_zone;
  logic push;
  logic push_rdy;
  logic [7:0] conversion_config_byte;
  logic [55:0] rom_body;
  logic [7:0] rom_crc;
  logic [63:0] rom_w;
  logic [63:0] sp_body;
  logic [7:0] sp_crc;
  logic [71:0] sp_w;
  logic rom_bit;

  //////////////////////////////////////////////////////////////////////
  // Next state after an addressing command byte
  function automatic swt_st_type rom_next(input logic [7:0] b, input logic alm);
    case (b)
      CMD_READ_CODE: rom_next = ST_READROM;
      CMD_MATCH_CODE: rom_next = ST_MATCH;
      CMD_SKIP_CODE: rom_next = ST_FNCMD;
      CMD_SEARCH: rom_next = ST_SEARCH;
      CMD_ALARM_SEARCH: rom_next = alm ? ST_SEARCH : ST_IDLE;
      default: rom_next = ST_IDLE;
    endcase
  endfunction

  // Worst-case conversion length halves per dropped resolution bit
  function automatic logic [VW-1:0] conv_lim(input logic [1:0] r);
    conv_lim = VW'(CONV_N >> (2'h3 - r));
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Identification code and scratchpad images
  assign rom_body = {SERIAL, TYPE_CODE};
  assign rom_w = {rom_crc, rom_body};

  swt_crc8 #(
    .NBYTES(7)
  ) u_rom_crc (
    .data_i(rom_body),
    .crc_o(rom_crc)
  );

  // Reserved bits are fixed so a write cannot disturb them
  assign conversion_config_byte = {CFG_BIT7_VAL, res_ff, CFG_LOW_VAL};
  assign sp_body = {SP_RSVD, conversion_config_byte, tl_ff, th_ff, temp_ff};
  assign sp_w = {sp_crc, sp_body};

  // Combinational so the check byte tracks every scratchpad change
  swt_crc8 #(
    .NBYTES(8)
  ) u_sp_crc (
    .data_i(sp_body),
    .crc_o(sp_crc)
  );

  assign rom_bit = rom_w[cnt_ff[5:0]];
  assign resolution_o = res_ff;
  assign conv_busy_o = conv_cnt_ff != '0;

  //////////////////////////////////////////////////////////////////////
  // Line sensing: edge and long-low detection
  assign fall = dq_q_ff && !dq_i;
  assign rst_hit = !dq_i && (low_cnt_ff == CW'(RST_N - 1));

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dq_q_ff <= 1'b1;
    end else begin
      dq_q_ff <= dq_i;
    end
  end

  // Saturates so a line held low forever keeps the device in reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_cnt_ff <= '0;
    end else if (dq_i) begin
      low_cnt_ff <= '0;
    end else if (low_cnt_ff != CW'(RST_N - 1)) begin
      low_cnt_ff <= low_cnt_ff + CW'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Slot engine
  // Slots start only on a falling edge, so idle gaps may last forever
  assign slot_zone = (st_ff == ST_ROMCMD) || (st_ff == ST_READROM) || (st_ff == ST_MATCH) ||
                     (st_ff == ST_SEARCH) || (st_ff == ST_FNCMD) || (st_ff == ST_WRSP) ||
                     (st_ff == ST_RDSP);
  assign bit_stb = slot_ff && (tm_ff == CW'(SMP_N - 1));
  assign rb = dq_i;
  assign rx_byte = {rb, sh_ff[7:1]};

  // Bit to send in the current slot; LSB of each byte goes first
  always_comb begin
    tx_mode = 1'b0;
    tx_bit = 1'b1;
    case (st_ff)
      ST_READROM: begin
        tx_mode = 1'b1;
        tx_bit = rom_bit;
      end
      ST_SEARCH: begin
        tx_mode = sub_ff != 2'h2;
        tx_bit = (sub_ff == 2'h0) ? rom_bit : !rom_bit;
      end
      ST_RDSP: begin
        tx_mode = 1'b1;
        tx_bit = sp_w[cnt_ff];
      end
      default: begin
        tx_mode = 1'b0;
        tx_bit = 1'b1;
      end
    endcase
  end

  // Shared timer: presence wait, presence low, slot sample point
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tm_ff <= '0;
    end else if (rst_hit || (st_ff == ST_WRISE)) begin
      tm_ff <= '0;
    end else if (st_ff == ST_PWAIT) begin
      tm_ff <= (tm_ff == CW'(PW_N - 1)) ? '0 : tm_ff + CW'(1);
    end else if (st_ff == ST_PLOW) begin
      tm_ff <= (tm_ff == CW'(PL_N - 1)) ? '0 : tm_ff + CW'(1);
    end else if (slot_ff) begin
      tm_ff <= bit_stb ? '0 : tm_ff + CW'(1);
    end
  end

  // A full FIFO holds off new slots so no received byte is lost
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      slot_ff <= 1'b0;
    end else if (rst_hit || !slot_zone) begin
      slot_ff <= 1'b0;
    end else if (bit_stb) begin
      slot_ff <= 1'b0;
    end else if (fall && push_rdy) begin
      slot_ff <= 1'b1;
    end
  end

  // Pull-down only; releasing the line lets the pull-up raise it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      drv_ff <= 1'b0;
    end else if (rst_hit) begin
      drv_ff <= 1'b0;
    end else if (st_ff == ST_PWAIT && tm_ff == CW'(PW_N - 1)) begin
      drv_ff <= 1'b1;
    end else if (st_ff == ST_PLOW && tm_ff == CW'(PL_N - 1)) begin
      drv_ff <= 1'b0;
    end else if (bit_stb) begin
      drv_ff <= 1'b0;
    end else if (slot_zone && !slot_ff && fall && push_rdy) begin
      drv_ff <= tx_mode && !tx_bit;
    end
  end

  assign dq_o = 1'b0;
  assign dq_oe_o = drv_ff;

  //////////////////////////////////////////////////////////////////////
  // Transaction sequencer
  // Check bytes are only sent, never tested, so no path stops on them
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= ST_IDLE;
      cnt_ff <= '0;
      sub_ff <= '0;
    end else if (rst_hit) begin
      st_ff <= ST_WRISE;
      cnt_ff <= '0;
      sub_ff <= '0;
    end else begin
      case (st_ff)
        ST_WRISE: begin
          if (dq_i) begin
            st_ff <= ST_PWAIT;
          end
        end
        ST_PWAIT: begin
          if (tm_ff == CW'(PW_N - 1)) begin
            st_ff <= ST_PLOW;
          end
        end
        ST_PLOW: begin
          if (tm_ff == CW'(PL_N - 1)) begin
            st_ff <= ST_ROMCMD;
          end
        end
        ST_ROMCMD: begin
          if (bit_stb) begin
            cnt_ff <= (cnt_ff == 7'h07) ? '0 : cnt_ff + 7'h01;
            if (cnt_ff == 7'h07) begin
              st_ff <= rom_next(rx_byte, alarm_i);
            end
          end
        end
        ST_READROM: begin
          if (bit_stb) begin
            cnt_ff <= (cnt_ff == 7'h3f) ? '0 : cnt_ff + 7'h01;
            if (cnt_ff == 7'h3f) begin
              st_ff <= ST_FNCMD;
            end
          end
        end
        ST_MATCH: begin
          if (bit_stb) begin
            if (rb != rom_bit) begin
              st_ff <= ST_IDLE;
            end else if (cnt_ff == 7'h3f) begin
              st_ff <= ST_FNCMD;
              cnt_ff <= '0;
            end else begin
              cnt_ff <= cnt_ff + 7'h01;
            end
          end
        end
        ST_SEARCH: begin
          if (bit_stb) begin
            sub_ff <= (sub_ff == 2'h2) ? '0 : sub_ff + 2'h1;
            if (sub_ff == 2'h2) begin
              if (rb != rom_bit || cnt_ff == 7'h3f) begin
                st_ff <= ST_IDLE;
              end else begin
                cnt_ff <= cnt_ff + 7'h01;
              end
            end
          end
        end
        ST_FNCMD: begin
          if (bit_stb) begin
            cnt_ff <= (cnt_ff == 7'h07) ? '0 : cnt_ff + 7'h01;
            if (cnt_ff == 7'h07) begin
              case (rx_byte)
                CMD_WRITE_SP: st_ff <= ST_WRSP;
                CMD_READ_SP: st_ff <= ST_RDSP;
                default: st_ff <= ST_IDLE;
              endcase
            end
          end
        end
        ST_WRSP: begin
          if (bit_stb) begin
            cnt_ff <= cnt_ff + 7'h01;
            if (cnt_ff == 7'h17) begin
              st_ff <= ST_IDLE;
            end
          end
        end
        ST_RDSP: begin
          if (bit_stb) begin
            cnt_ff <= cnt_ff + 7'h01;
            if (cnt_ff == 7'h47) begin
              st_ff <= ST_IDLE;
            end
          end
        end
        default: begin
          st_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Receive shifter, LSB arrives first
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sh_ff <= '0;
    end else if (bit_stb && !tx_mode) begin
      sh_ff <= rx_byte;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Scratchpad writes: high limit, low limit, then configuration
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      th_ff <= TH_RESET;
      tl_ff <= TL_RESET;
      res_ff <= RES_RESET;
    end else if (st_ff == ST_WRSP && bit_stb && cnt_ff[2:0] == 3'h7) begin
      case (cnt_ff[4:3])
        2'h0: th_ff <= rx_byte;
        2'h1: tl_ff <= rx_byte;
        default: res_ff <= {rx_byte[CFG_RES_HI_POS], rx_byte[CFG_RES_LO_POS]};
      endcase
    end
  end

  // Conversion timer; result latched only when the worst case has elapsed
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      conv_cnt_ff <= '0;
      temp_ff <= TEMP_RESET;
    end else if (st_ff == ST_FNCMD && bit_stb && cnt_ff == 7'h07 && rx_byte == CMD_CONVERT) begin
      conv_cnt_ff <= conv_lim(res_ff);
    end else if (conv_cnt_ff != '0) begin
      conv_cnt_ff <= conv_cnt_ff - VW'(1);
      if (conv_cnt_ff == VW'(1)) begin
        temp_ff <= temp_i;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Function bytes from the master toward the user side
  assign push = bit_stb && cnt_ff[2:0] == 3'h7 && (st_ff == ST_FNCMD || st_ff == ST_WRSP);

  swt_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_data_i(rx_byte),
    .in_valid_i(push),
    .in_ready_o(push_rdy),
    .out_data_o(fn_byte_o),
    .out_valid_o(fn_valid_o),
    .out_ready_i(fn_ready_i)
  );

  //////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_rst_release;
    st_ff == ST_WRISE && dq_i && !rst_hit;
  endsequence

  property p_pres_wait;
    s_rst_release |=> st_ff == ST_PWAIT && !dq_oe_o ##1 !dq_oe_o;
  endproperty
  a_pres_wait: assert property (p_pres_wait) else $error("presence drove too early");

  property p_pres_end;
    (st_ff == ST_PLOW && tm_ff == CW'(PL_N - 1) && !rst_hit) |=> !dq_oe_o && st_ff == ST_ROMCMD;
  endproperty
  a_pres_end: assert property (p_pres_end) else $error("presence end wrong");

  property p_bus_reset;
    (!dq_i && low_cnt_ff == CW'(RST_N - 1)) |=> st_ff == ST_WRISE && !dq_oe_o;
  endproperty
  a_bus_reset: assert property (p_bus_reset) else $error("long low not taken as reset");

  property p_cfg_fixed;
    conversion_config_byte[7] == 1'b0 && conversion_config_byte[4:0] == 5'h1f &&
      conversion_config_byte[6:5] == resolution_o;
  endproperty
  a_cfg_fixed: assert property (p_cfg_fixed) else $error("config byte layout wrong");

  property p_conv_time;
    (st_ff == ST_FNCMD && bit_stb && cnt_ff == 7'h07 && rx_byte == CMD_CONVERT && !rst_hit)
      |=> conv_cnt_ff == VW'(CONV_N / (8 >> $past(res_ff)));
  endproperty
  a_conv_time: assert property (p_conv_time) else $error("conversion length wrong");

  property p_bad_cmd;
    (st_ff == ST_ROMCMD && bit_stb && cnt_ff == 7'h07 && !rst_hit && rx_byte != CMD_READ_CODE &&
     rx_byte != CMD_MATCH_CODE && rx_byte != CMD_SKIP_CODE && rx_byte != CMD_SEARCH &&
     rx_byte != CMD_ALARM_SEARCH) |=> st_ff == ST_IDLE;
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("unknown command not ignored");

  property p_skip;
    (st_ff == ST_ROMCMD && bit_stb && cnt_ff == 7'h07 && rx_byte == CMD_SKIP_CODE && !rst_hit)
      |=> st_ff == ST_FNCMD && cnt_ff == 7'h00;
  endproperty
  a_skip: assert property (p_skip) else $error("skip did not select");

  property p_alarm;
    (st_ff == ST_ROMCMD && bit_stb && cnt_ff == 7'h07 && rx_byte == CMD_ALARM_SEARCH &&
     !rst_hit) |=> st_ff == ($past(alarm_i) ? ST_SEARCH : ST_IDLE);
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm search gating wrong");

  property p_match_fail;
    (st_ff == ST_MATCH && bit_stb && rb != rom_bit && !rst_hit) |=> st_ff == ST_IDLE;
  endproperty
  a_match_fail: assert property (p_match_fail) else $error("mismatch kept device selected");

  property p_idle_quiet;
    (st_ff == ST_IDLE) |-> !dq_oe_o;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("unselected device drives line");

  property p_lsb_first;
    (st_ff == ST_ROMCMD && bit_stb && !rst_hit) |=> sh_ff[7] == $past(rb);
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("bit order wrong");
endmodule

// file: tb/swt_master_model.sv
`timescale 1ns/1ps
module swt_master_model
  import swt_pkg::*;
(
  input wire logic clk_i,
  input wire logic dq_oe_i,
  input wire logic dq_i,
  output logic dq_line_o
);
  logic pull_low = 1'b0;
  logic [7:0] rd_byte = 8'h00;
  logic [7:0] crc_acc = 8'h00;
  event got_byte;
  // Wired-AND with the pull-up, so a released line reads high
  // The device only pulls low when its enable is up and its value is 0
  assign dq_line_o = ~(pull_low | (dq_oe_i & ~dq_i));
  // One check-value step, bit taken least significant first
  function automatic logic [7:0] crc_bit(input logic [7:0] c, input logic b);
    crc_bit = (c >> 1) ^ ((c[0] ^ b) ? CRC_POLY_REV : 8'h00);
  endfunction
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Long low, release, then watch for the presence answer
  task automatic bus_reset(output logic seen);
    pull_low = 1'b1;
    wait_cyc(210);
    pull_low = 1'b0;
    seen = 1'b0;
    repeat (120) begin
      wait_cyc(1);
      if (dq_line_o === 1'b0) seen = 1'b1;
    end
  endtask
  // Short low for a one, long low for a zero; the idle gap may be any length
  task automatic put_bit(input logic b);
    pull_low = 1'b1;
    wait_cyc(b ? 2 : 15);
    pull_low = 1'b0;
    wait_cyc(b ? 16 : 3);
  endtask
  // Read slot: brief low, then sample well before the device lets go
  task automatic get_bit(output logic b);
    pull_low = 1'b1;
    wait_cyc(1);
    pull_low = 1'b0;
    wait_cyc(5);
    b = dq_line_o;
    crc_acc = crc_bit(crc_acc, b);
    wait_cyc(12);
  endtask
  task automatic put_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) put_bit(v[i]);
  endtask
  task automatic get_byte();
    logic b;
    for (int i = 0; i < 8; i++) begin
      get_bit(b);
      rd_byte[i] = b;
    end
    -> got_byte;
  endtask
endmodule

// file: tb/single_wire_rom_crc_config_test.sv
`timescale 1ns/1ps
module single_wire_rom_crc_config_test;
  import swt_pkg::*;
  localparam logic [47:0] SER = 48'h0000_1234_5678; // Arbitrary serial
  localparam logic [7:0] TYP = 8'h5a; // Arbitrary type code
  localparam int CONV = 800;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] temp_i = 16'h0000;
  logic alarm_i = 1'b0;
  logic fn_ready_i = 1'b0;
  logic stall = 1'b0;
  logic dq_line, dq_val, dq_oe_o, conv_busy_o, fn_valid_o;
  logic [1:0] resolution_o;
  logic [7:0] fn_byte_o;
  logic [63:0] code;
  logic [7:0] exp_q[$];
  logic [7:0] fn_q[$];
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  int busy_cnt = 0;
  int seed = 32'h7aca02a6;

  always #2.5 clk_i = ~clk_i;

  // Identity defaults are kept; only the timing is shortened for the run
  swt_wire_slave #(.RST_N(200), .PW_N(20), .PL_N(60), .SMP_N(10), .CONV_N(CONV))
    uut (.clk_i(clk_i), .rst_i(rst_i), .dq_i(dq_line),
    .dq_o(dq_val), .dq_oe_o(dq_oe_o), .temp_i(temp_i), .alarm_i(alarm_i),
    .conv_busy_o(conv_busy_o), .resolution_o(resolution_o), .fn_byte_o(fn_byte_o),
    .fn_valid_o(fn_valid_o), .fn_ready_i(fn_ready_i));
  swt_master_model mm (.clk_i(clk_i), .dq_oe_i(dq_oe_o), .dq_i(dq_val), .dq_line_o(dq_line));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic ok, input string what);
    total_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask
  task automatic send_fn(input logic [7:0] v);
    fn_q.push_back(v);
    mm.put_byte(v);
  endtask
  task automatic open_skip(input logic [7:0] f);
    logic p;
    mm.bus_reset(p);
    chk(p, "no presence");
    mm.put_byte(CMD_SKIP_CODE);
    send_fn(f);
  endtask
  // Expected scratchpad with its check byte worked out here
  task automatic read_sp(input logic [15:0] t, input logic [7:0] h, l, input logic [1:0] r);
    logic [7:0] b [9];
    b = '{t[7:0], t[15:8], h, l, {1'b0, r, 5'h1f}, 8'hff, 8'h0c, 8'h10, 8'h00};
    for (int i = 0; i < 64; i++) b[8] = mm.crc_bit(b[8], b[i / 8][i % 8]);
    for (int i = 0; i < 9; i++) exp_q.push_back(b[i]);
    repeat (9) mm.get_byte();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Bytes read off the line against the oldest note
  always @(mm.got_byte) begin
    total_checks++;
    if (exp_q.size() == 0 || mm.rd_byte !== exp_q[0]) begin
      failures++;
      $display("Error at %0t: line byte %h", $time, mm.rd_byte);
    end
    if (exp_q.size() != 0) exp_q.delete(0);
  end
  // Random ready so the buffer is stalled at times
  always @(posedge clk_i) begin
    #1 fn_ready_i = !stall && ($random(seed) & 1);
  end
  // FIFO pops, busy count, hang limit; sampled mid-cycle where outputs are settled
  always @(negedge clk_i) begin
    cycles++;
    if (conv_busy_o === 1'b1) busy_cnt++;
    if (fn_valid_o === 1'b1 && fn_ready_i === 1'b1) begin
      total_checks++;
      if (fn_q.size() == 0 || fn_byte_o !== fn_q[0]) begin
        failures++;
        $display("Error at %0t: function byte %h", $time, fn_byte_o);
      end
      if (fn_q.size() != 0) fn_q.delete(0);
    end
    if (cycles > 90000) begin
      failures++;
      $display("Error at %0t: timeout", $time);
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic p, a, b;
    logic [7:0] c, th, tl, cf;
    logic [15:0] tv;
    code[55:0] = {SER, TYP};
    c = 8'h00;
    for (int i = 0; i < 56; i++) c = mm.crc_bit(c, code[i]);
    code[63:56] = c;
    repeat (10) @(posedge clk_i);
    #1 rst_i = 1'b0;
    chk(resolution_o === 2'h3 && conv_busy_o === 1'b0 && dq_oe_o === 1'b0, "reset");
    open_skip(CMD_READ_SP);
    read_sp(TEMP_RESET, TH_RESET, TL_RESET, RES_RESET);
    mm.bus_reset(p);
    mm.put_byte(CMD_READ_CODE);
    mm.crc_acc = 8'h00;
    for (int i = 0; i < 64; i += 8) exp_q.push_back(code[i+:8]);
    repeat (8) mm.get_byte();
    chk(p === 1'b1 && mm.crc_acc === 8'h00, "code check");
    $display("test code read done");
    // Each resolution; the first two writes queue up in the buffer while it is stalled
    for (int r = 0; r < 4; r++) begin
      th = $random(seed);
      tl = $random(seed);
      cf = $random(seed);
      tv = $random(seed);
      cf[6:5] = r[1:0];
      stall = (r < 2);
      open_skip(CMD_WRITE_SP);
      send_fn(th);
      send_fn(tl);
      send_fn(cf);
      chk(resolution_o === r[1:0], "resolution");
      stall = 1'b0;
      temp_i = tv;
      busy_cnt = 0;
      open_skip(CMD_CONVERT);
      // Line left high while converting, as a strong pull-up would hold it
      for (int k = 0; k < 1000 && conv_busy_o !== 1'b0; k++) mm.wait_cyc(1);
      chk(busy_cnt == (CONV >> (3 - r)), "conversion length");
      open_skip(CMD_READ_SP);
      read_sp(tv, th, tl, r[1:0]);
    end
    $display("test resolution done");
    // Exact match, then the low bit of every byte flipped; the first read is cut short by a bus reset
    for (int k = 0; k < 2; k++) begin
      mm.bus_reset(p);
      mm.put_byte(CMD_MATCH_CODE);
      for (int i = 0; i < 64; i += 8) mm.put_byte(code[i+:8] ^ {7'h00, k[0]});
      // Note first: the byte may be popped before the last slot ends
      if (k == 0) fn_q.push_back(CMD_READ_SP);
      mm.put_byte(CMD_READ_SP);
      exp_q.push_back(k == 0 ? tv[7:0] : 8'hff);
      mm.get_byte();
    end
    $display("test match done");
    // Code search, alarm search with and without the flag, each after a fresh reset
    for (int k = 0; k < 3; k++) begin
      alarm_i = (k == 1);
      mm.bus_reset(p);
      mm.put_byte(k == 0 ? CMD_SEARCH : CMD_ALARM_SEARCH);
      for (int i = 0; i < 64; i++) begin
        mm.get_bit(a);
        mm.get_bit(b);
        chk(k < 2 ? (a === code[i] && b === ~code[i]) : (a & b), "search bit");
        mm.put_bit(code[i]);
      end
    end
    // No reset before the commands, so the device must stay silent
    mm.put_byte(CMD_SKIP_CODE);
    mm.put_byte(CMD_READ_SP);
    exp_q.push_back(8'hff);
    mm.get_byte();
    mm.wait_cyc(100);
    chk(fn_q.size() == 0 && exp_q.size() == 0, "notes left");
    $display("test search done");
    report_and_stop();
  end
endmodule
